// >>> hw/p1284_rev_pkg.sv
// Purpose: Shared constants and types for the reverse-direction
//          parallel port handshake engine.
// Assumes: 50 MHz clock, Avalon-MM register access with byte addresses.
// Notes:   Control-line nibble order is {busy, pError, select, nFault}.
package p1284_rev_pkg;

	localparam int CLK_PERIOD_NS = 20;
	localparam int HS_DELAY_NS = 500;
	localparam int HS_DELAY_CYCLES =
		(HS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register byte offsets
	localparam logic [4:0] OFS_MODE = 5'h00;
	localparam logic [4:0] OFS_HOLD = 5'h04;
	localparam logic [4:0] OFS_TRANSFER = 5'h08;
	localparam logic [4:0] OFS_CTRL = 5'h0C;
	localparam logic [4:0] OFS_TIMING = 5'h10;
	localparam logic [4:0] OFS_STATUS = 5'h14;

	// Status register bit positions
	localparam int ST_REQUEST = 0;
	localparam int ST_IDLE = 1;
	localparam int ST_ILLEGAL = 2;
	localparam int ST_EVENT = 3;
	localparam int ST_HOLD_FULL = 4;

	// Control register: [3:0] status lines, then the single lines
	localparam int CT_PTRCLK = 4;
	localparam int CT_HOSTBUSY = 5;
	localparam int CT_HOSTCLK = 6;
	localparam int CT_ACTIVE = 7;
	localparam int CT_NINIT = 8;

	localparam logic [8:0] CTRL_RESET = 9'h1FF;
	localparam logic [7:0] TIMING_RESET = 8'(HS_DELAY_CYCLES);
	localparam logic [7:0] BYTE_RESET = 8'h00;

	typedef enum logic [2:0] {
		MODE_HOST_NEG,
		MODE_HOST_NIBBLE,
		MODE_PERIPH_NIBBLE,
		MODE_HOST_BYTE,
		MODE_PERIPH_NEG
	} mode_e;

	typedef struct packed {
		logic nInit;
		logic p1284Active;
		logic hostClk;
		logic hostBusy;
		logic ptrClk;
		logic [3:0] status;
		logic [7:0] data;
	} pins_in_s;

	typedef struct packed {
		logic hostOe;
		logic nInit;
		logic p1284Active;
		logic hostClk;
		logic hostBusy;
		logic periphOe;
		logic ptrClk;
		logic [3:0] status;
	} pins_out_s;

endpackage

// >>> hw/hs_delay_timer.sv
// Purpose: Down-counter that times handshake setup and hold intervals.
// Assumes: count is at least one cycle.
// Notes:   done is low in the cycle of start and while counting.
`timescale 1ns/10ps
module hs_delay_timer (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [7:0] count,
	output logic done
);
	import p1284_rev_pkg::*;

	logic [7:0] cnt_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_r <= BYTE_RESET;
		end else if (start) begin
			cnt_r <= count;
		end else if (cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end
	end

	assign done = (cnt_r == 8'h00) && !start;
endmodule

// >>> hw/line_edge_sense.sv
// Purpose: Rising and falling edge pulses for a group of lines.
// Assumes: Lines are synchronous to clk.
// Notes:   Previous level starts high, the idle level of these lines.
`timescale 1ns/10ps
module line_edge_sense #(
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_line
			logic prev_r;
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					prev_r <= 1'b1;
				end else begin
					prev_r <= level[i];
				end
			end
			assign rise[i] = level[i] && !prev_r;
			assign fall[i] = !level[i] && prev_r;
		end
	endgenerate
endmodule

// >>> hw/rev_nibble_byte_engine.sv
// Purpose: Reverse-direction handshake engine: host nibble, peripheral
//          nibble and host byte transfers, with Avalon-MM registers.
// Assumes: Cable lines are synchronous to clk; waitrequest answers a
//          request one cycle after it is first seen.
// Notes:   Handshake delays count clk cycles from the timing register.
//
// Summary of operation
// - Host nibble: drive HostBusy low, wait request clear and PtrClk low.
// - Nibble order busy, pError, select, nFault into bits 3-0 then 7-4.
// - Raise HostBusy, await PtrClk high, lower it, latch upper nibble.
// - After second nibble raise HostBusy, set request; continue if data.
// - nDataAvail high at PtrClk rise sets idle and stalls the engine.
// - Host nibble and host byte modes raise no status-change events.
// - Peripheral nibble entry sets request and idle, routes bits 3-0.
// - Holding write while idle moves to transfer register, request blips.
// - Low nibble settles, PtrClk low, HostBusy high, route bits 7-4.
// - Upper nibble settles, HostBusy low, PtrClk low; restore status lines.
// - Idle until next byte, load, settle, raise PtrClk, route low nibble.
// - Peripheral nibble mode flags both edges of P1284Active and nInit.
// - P1284Active falling outside the legal window sets the illegal flag.
// - Host byte entry clears idle and waits one handshake delay.
// - Host byte: HostBusy low, PtrClk low, latch data, HostClk low.
// - Request clear, PtrClk high, delay met: raise HostClk, check data.
`timescale 1ns/10ps
module rev_nibble_byte_engine (
	input wire logic clk,
	input wire logic reset,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input p1284_rev_pkg::pins_in_s pinsIn,
	output p1284_rev_pkg::pins_out_s pinsOut
);
	import p1284_rev_pkg::*;

	typedef enum logic [3:0] {
		S_OFF, S_HN_LOW1, S_HN_HIGH1, S_HN_LOW2, S_HN_HIGH2,
		S_HB_SETUP, S_HB_REQ, S_HB_ACK,
		S_PN_WAIT, S_PN_SETUP_LO, S_PN_HB_HI1, S_PN_SETUP_HI,
		S_PN_HB_HI2, S_PN_NEXT, S_PN_HB_LO, S_STALL
	} state_e;

	typedef enum logic [1:0] {ROUTE_CTRL, ROUTE_LO, ROUTE_HI} route_e;

	mode_e mode_r;
	mode_e modeNew;
	state_e state_r;
	route_e route_r;
	logic ack_r;
	logic busWr;
	logic busRd;
	logic modeWr;
	logic ohrWr;
	logic iorRd;
	logic statusWr;
	logic [8:0] ctrl_r;
	logic [7:0] timing_r;
	logic [7:0] ohr_r;
	logic [7:0] ior_r;
	logic transfer_request_flag_r;
	logic idle_r;
	logic ohrFull_r;
	logic illegal_r;
	logic event_r;
	logic hostBusy_r;
	logic hostClk_r;
	logic ptrClk_r;
	logic tmrStart_r;
	logic tmrDone;
	logic [1:0] lineRise;
	logic [1:0] lineFall;
	logic [31:0] rdValue;
	logic [3:0] nib;
	logic nDataAvail;
	logic hostMode;
	pins_out_s pinsNxt;

	assign nib = pinsIn.status;
	assign nDataAvail = pinsIn.status[0];
	assign hostMode = (mode_r == MODE_HOST_NIBBLE) ||
		(mode_r == MODE_HOST_BYTE);

	// Avalon slave: one wait cycle, then the answer
	assign waitrequest = (read || write) && !ack_r;
	assign busWr = write && ack_r;
	assign busRd = read && ack_r;
	assign modeWr = busWr && (address == OFS_MODE);
	assign ohrWr = busWr && (address == OFS_HOLD);
	assign iorRd = busRd && (address == OFS_TRANSFER);
	assign statusWr = busWr && (address == OFS_STATUS);
	assign modeNew = (writedata[2:0] > 3'(MODE_PERIPH_NEG)) ?
		MODE_HOST_NEG : mode_e'(writedata[2:0]);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (read || write) && !ack_r;
		end
	end

	always_comb begin
		rdValue = 32'h0000_0000;
		if (address == OFS_MODE) begin
			rdValue[2:0] = mode_r;
		end else if (address == OFS_HOLD) begin
			rdValue[7:0] = ohr_r;
		end else if (address == OFS_TRANSFER) begin
			rdValue[7:0] = ior_r;
		end else if (address == OFS_CTRL) begin
			rdValue[8:0] = ctrl_r;
		end else if (address == OFS_TIMING) begin
			rdValue[7:0] = timing_r;
		end else if (address == OFS_STATUS) begin
			rdValue[ST_REQUEST] = transfer_request_flag_r;
			rdValue[ST_IDLE] = idle_r;
			rdValue[ST_ILLEGAL] = illegal_r;
			rdValue[ST_EVENT] = event_r;
			rdValue[ST_HOLD_FULL] = ohrFull_r;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			readdata <= 32'h0000_0000;
		end else if (read && !ack_r) begin
			readdata <= rdValue;
		end
	end

	// Software registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_r <= MODE_HOST_NEG;
			ctrl_r <= CTRL_RESET;
			timing_r <= TIMING_RESET;
			ohr_r <= BYTE_RESET;
		end else begin
			if (modeWr) begin
				mode_r <= modeNew;
			end
			if (busWr && address == OFS_CTRL) begin
				ctrl_r <= writedata[8:0];
			end
			if (busWr && address == OFS_TIMING) begin
				timing_r <= writedata[7:0];
			end
			if (ohrWr) begin
				ohr_r <= writedata[7:0];
			end
		end
	end

	hs_delay_timer u_timer (
		.clk(clk),
		.reset(reset),
		.start(tmrStart_r),
		.count(timing_r),
		.done(tmrDone)
	);

	line_edge_sense #(.W(2)) u_edges (
		.clk(clk),
		.reset(reset),
		.level({pinsIn.nInit, pinsIn.p1284Active}),
		.rise(lineRise),
		.fall(lineFall)
	);

	// Event and illegal flags; a set beats a same-cycle clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			event_r <= 1'b0;
			illegal_r <= 1'b0;
		end else begin
			if (statusWr && writedata[ST_EVENT]) begin
				event_r <= 1'b0;
			end
			if (statusWr && writedata[ST_ILLEGAL]) begin
				illegal_r <= 1'b0;
			end
			if (mode_r == MODE_PERIPH_NIBBLE &&
				(lineRise != 2'b00 || lineFall != 2'b00)) begin
				event_r <= 1'b1;
			end
			if (mode_r == MODE_PERIPH_NIBBLE && lineFall[0] &&
				state_r != S_PN_HB_LO) begin
				illegal_r <= 1'b1;
			end
		end
	end

	// Handshake engine
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= S_OFF;
			route_r <= ROUTE_CTRL;
			ior_r <= BYTE_RESET;
			transfer_request_flag_r <= 1'b0;
			idle_r <= 1'b0;
			ohrFull_r <= 1'b0;
			hostBusy_r <= 1'b1;
			hostClk_r <= 1'b1;
			ptrClk_r <= 1'b1;
			tmrStart_r <= 1'b0;
		end else begin
			tmrStart_r <= 1'b0;
			if (iorRd || ohrWr) begin
				transfer_request_flag_r <= 1'b0;
			end
			if (modeWr) begin
				route_r <= ROUTE_CTRL;
				hostBusy_r <= 1'b1;
				hostClk_r <= 1'b1;
				ptrClk_r <= 1'b1;
				ohrFull_r <= 1'b0;
				case (modeNew)
				MODE_HOST_NIBBLE: begin
					state_r <= S_HN_LOW1;
				end
				MODE_HOST_BYTE: begin
					idle_r <= 1'b0;
					tmrStart_r <= 1'b1;
					state_r <= S_HB_SETUP;
				end
				MODE_PERIPH_NIBBLE: begin
					transfer_request_flag_r <= 1'b1;
					idle_r <= 1'b1;
					route_r <= ROUTE_LO;
					state_r <= S_PN_WAIT;
				end
				default: begin
					state_r <= S_OFF;
				end
				endcase
			end else begin
				case (state_r)
				S_HN_LOW1: begin
					hostBusy_r <= 1'b0;
					if (!transfer_request_flag_r && !pinsIn.ptrClk && !hostBusy_r) begin
						ior_r[3:0] <= nib;
						hostBusy_r <= 1'b1;
						state_r <= S_HN_HIGH1;
					end
				end
				S_HN_HIGH1: begin
					if (pinsIn.ptrClk) begin
						hostBusy_r <= 1'b0;
						state_r <= S_HN_LOW2;
					end
				end
				S_HN_LOW2: begin
					if (!pinsIn.ptrClk) begin
						ior_r[7:4] <= nib;
						hostBusy_r <= 1'b1;
						transfer_request_flag_r <= 1'b1;
						state_r <= S_HN_HIGH2;
					end
				end
				S_HN_HIGH2: begin
					if (pinsIn.ptrClk && !nDataAvail) begin
						hostBusy_r <= 1'b0;
						state_r <= S_HN_LOW1;
					end else if (pinsIn.ptrClk) begin
						idle_r <= 1'b1;
						state_r <= S_STALL;
					end
				end
				S_HB_SETUP: begin
					if (tmrDone) begin
						hostBusy_r <= 1'b0;
						state_r <= S_HB_REQ;
					end
				end
				S_HB_REQ: begin
					hostBusy_r <= 1'b0;
					if (!pinsIn.ptrClk && !hostBusy_r) begin
						ior_r <= pinsIn.data;
						transfer_request_flag_r <= 1'b1;
						hostBusy_r <= 1'b1;
						hostClk_r <= 1'b0;
						tmrStart_r <= 1'b1;
						state_r <= S_HB_ACK;
					end
				end
				S_HB_ACK: begin
					if (!transfer_request_flag_r && pinsIn.ptrClk && tmrDone) begin
						hostClk_r <= 1'b1;
						if (!nDataAvail) begin
							hostBusy_r <= 1'b0;
							state_r <= S_HB_REQ;
						end else begin
							idle_r <= 1'b1;
							state_r <= S_STALL;
						end
					end
				end
				S_PN_WAIT: begin
					if (ohrFull_r) begin
						ior_r <= ohr_r;
						ohrFull_r <= 1'b0;
						transfer_request_flag_r <= 1'b1;
						idle_r <= 1'b0;
						tmrStart_r <= 1'b1;
						state_r <= S_PN_SETUP_LO;
					end
				end
				S_PN_SETUP_LO: begin
					if (tmrDone) begin
						ptrClk_r <= 1'b0;
						state_r <= S_PN_HB_HI1;
					end
				end
				S_PN_HB_HI1: begin
					if (pinsIn.hostBusy) begin
						ptrClk_r <= 1'b1;
						route_r <= ROUTE_HI;
						tmrStart_r <= 1'b1;
						state_r <= S_PN_SETUP_HI;
					end
				end
				S_PN_SETUP_HI: begin
					if (tmrDone && !pinsIn.hostBusy) begin
						ptrClk_r <= 1'b0;
						state_r <= S_PN_HB_HI2;
					end
				end
				S_PN_HB_HI2: begin
					if (pinsIn.hostBusy) begin
						route_r <= ROUTE_CTRL;
						state_r <= S_PN_NEXT;
						if (!ohrFull_r) begin
							idle_r <= 1'b1;
						end
					end
				end
				S_PN_NEXT: begin
					if (ohrFull_r) begin
						ior_r <= ohr_r;
						ohrFull_r <= 1'b0;
						transfer_request_flag_r <= 1'b1;
						idle_r <= 1'b0;
						tmrStart_r <= 1'b1;
						state_r <= S_PN_HB_LO;
					end
				end
				S_PN_HB_LO: begin
					if (tmrDone && !ptrClk_r && !tmrStart_r) begin
						ptrClk_r <= 1'b1;
					end
					if (ptrClk_r && !pinsIn.hostBusy) begin
						route_r <= ROUTE_LO;
						tmrStart_r <= 1'b1;
						state_r <= S_PN_SETUP_LO;
					end
				end
				default: begin
					state_r <= state_r;
				end
				endcase
			end
			if (ohrWr) begin
				ohrFull_r <= 1'b1;
			end
		end
	end

	// Pin drive: engine lines in active modes, control register otherwise
	always_comb begin
		pinsNxt.hostOe = (mode_r == MODE_HOST_NEG) || hostMode;
		pinsNxt.periphOe = (mode_r == MODE_PERIPH_NIBBLE) ||
			(mode_r == MODE_PERIPH_NEG);
		pinsNxt.nInit = ctrl_r[CT_NINIT];
		pinsNxt.p1284Active = ctrl_r[CT_ACTIVE];
		pinsNxt.hostBusy = hostMode ? hostBusy_r : ctrl_r[CT_HOSTBUSY];
		pinsNxt.hostClk = (mode_r == MODE_HOST_BYTE) ? hostClk_r :
			ctrl_r[CT_HOSTCLK];
		pinsNxt.ptrClk = ctrl_r[CT_PTRCLK];
		pinsNxt.status = ctrl_r[3:0];
		if (mode_r == MODE_PERIPH_NIBBLE) begin
			pinsNxt.ptrClk = ptrClk_r;
			if (route_r == ROUTE_LO) begin
				pinsNxt.status = ior_r[3:0];
			end else if (route_r == ROUTE_HI) begin
				pinsNxt.status = ior_r[7:4];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pinsOut <= '{hostOe: 1'b1, periphOe: 1'b0, status: 4'hF,
				default: 1'b1};
		end else begin
			pinsOut <= pinsNxt;
		end
	end

	// Helper: cycles HostClk has been held low by the engine
	logic [8:0] clkLowCnt_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			clkLowCnt_r <= 9'h000;
		end else if (hostClk_r) begin
			clkLowCnt_r <= 9'h000;
		end else if (clkLowCnt_r != 9'h1FF) begin
			clkLowCnt_r <= clkLowCnt_r + 9'h001;
		end
	end

	sequence s_nib1_ready;
		state_r == S_HN_LOW1 && !transfer_request_flag_r && !pinsIn.ptrClk && !hostBusy_r
			&& !modeWr;
	endsequence

	sequence s_nib2_ready;
		state_r == S_HN_LOW2 && !pinsIn.ptrClk && !modeWr;
	endsequence

	a_low_nibble: assert property (@(posedge clk) disable iff (reset)
		s_nib1_ready |=> ior_r[3:0] == $past(nib) && hostBusy_r)
		else $error("low nibble not latched");

	a_high_nibble: assert property (@(posedge clk) disable iff (reset)
		s_nib2_ready |=> ior_r[7:4] == $past(nib) && transfer_request_flag_r && hostBusy_r)
		else $error("upper nibble or request wrong");

	a_nibble_idle: assert property (@(posedge clk) disable iff (reset)
		state_r == S_HN_HIGH2 && pinsIn.ptrClk && nDataAvail && !modeWr
		|=> idle_r && state_r == S_STALL)
		else $error("nibble idle not set");

	a_host_quiet: assert property (@(posedge clk) disable iff (reset)
		hostMode && !event_r |=> !event_r)
		else $error("status event in host mode");

	a_pn_entry: assert property (@(posedge clk) disable iff (reset)
		modeWr && modeNew == MODE_PERIPH_NIBBLE
		|=> transfer_request_flag_r && idle_r ##2 pinsOut.status == ior_r[3:0])
		else $error("peripheral nibble entry wrong");

	a_pn_settle: assert property (@(posedge clk) disable iff (reset)
		$rose(tmrStart_r) && state_r == S_PN_SETUP_LO
		|-> ptrClk_r [*8])
		else $error("PtrClk fell before settle time");

	a_byte_latch: assert property (@(posedge clk) disable iff (reset)
		state_r == S_HB_REQ && !pinsIn.ptrClk && !hostBusy_r && !modeWr
		|=> ior_r == $past(pinsIn.data) && transfer_request_flag_r && !hostClk_r
		##2 !pinsOut.hostClk)
		else $error("byte capture wrong");

	a_byte_hold: assert property (@(posedge clk) disable iff (reset)
		$rose(hostClk_r) && !$past(modeWr)
		|-> $past(clkLowCnt_r) >= 9'(timing_r))
		else $error("HostClk low too short");

	a_illegal_flag: assert property (@(posedge clk) disable iff (reset)
		mode_r == MODE_PERIPH_NIBBLE && lineFall[0] && state_r != S_PN_HB_LO
		|=> illegal_r)
		else $error("illegal operation not flagged");

	a_pn_event: assert property (@(posedge clk) disable iff (reset)
		mode_r == MODE_PERIPH_NIBBLE && lineRise[1] |=> event_r)
		else $error("nInit edge not flagged");
endmodule

// >>> tb/p1284_peer.sv
// Purpose: Far-side party: a nibble/byte peripheral or a nibble host.
// Assumes: Lines change just after rising edges.
// Notes:   Wire levels resolve from the engine's output enables.
`timescale 1ns/10ps
module p1284_peer (
	input wire logic clk,
	input wire logic lineActive,
	input wire logic lineInit,
	input p1284_rev_pkg::pins_out_s pinsOut,
	output p1284_rev_pkg::pins_in_s pinsIn,
	output logic timedOut
);
	import p1284_rev_pkg::*;
	logic busyDrv = 1'b0;
	logic ptrDrv = 1'b1;
	logic [3:0] statusDrv = 4'h2;
	logic [7:0] dataDrv = 8'h00;
	logic [3:0] seen;
	initial timedOut = 1'b0;
	assign pinsIn = {pinsOut.hostOe ? pinsOut.nInit : lineInit,
		pinsOut.hostOe ? pinsOut.p1284Active : lineActive,
		pinsOut.hostOe ? pinsOut.hostClk : 1'b1,
		pinsOut.hostOe ? pinsOut.hostBusy : busyDrv,
		pinsOut.periphOe ? pinsOut.ptrClk : ptrDrv,
		pinsOut.periphOe ? pinsOut.status : statusDrv, dataDrv};

	task automatic wait_for(input logic onPtr, input logic lvl);
		int n = 0;
		do begin
			@(negedge clk);
			seen = pinsIn.status;
			n++;
		end while (((onPtr ? pinsIn.ptrClk : pinsIn.hostBusy) !== lvl)
			&& n < 3000);
		if (n >= 3000) timedOut = 1'b1;
		@(posedge clk);
	endtask

	// Peripheral side of host nibble and host byte transfers
	task automatic send_byte(input logic [7:0] b, input logic more,
		input logic whole);
		wait_for(1'b0, 1'b0);
		if (whole) dataDrv <= b;
		else statusDrv <= b[3:0];
		@(posedge clk);
		ptrDrv <= 1'b0;
		wait_for(1'b0, 1'b1);
		if (!whole) begin
			statusDrv[0] <= 1'b0;
			ptrDrv <= 1'b1;
			wait_for(1'b0, 1'b0);
			statusDrv <= b[7:4];
			@(posedge clk);
			ptrDrv <= 1'b0;
			wait_for(1'b0, 1'b1);
		end
		// Released data lines stop showing the byte
		dataDrv <= ~b;
		statusDrv[0] <= ~more;
		ptrDrv <= 1'b1;
	endtask

	// Host side of peripheral nibble transfers
	task automatic take_byte(output logic [7:0] b);
		wait_for(1'b1, 1'b1);
		busyDrv <= 1'b0;
		wait_for(1'b1, 1'b0);
		b[3:0] = seen;
		busyDrv <= 1'b1;
		wait_for(1'b1, 1'b1);
		busyDrv <= 1'b0;
		wait_for(1'b1, 1'b0);
		b[7:4] = seen;
		busyDrv <= 1'b1;
	endtask
endmodule

// >>> tb/tb_rev_nibble_byte_engine.sv
// Purpose: Self-checking bench for the reverse handshake engine.
// Assumes: The peer model answers every cable handshake.
// Notes:   Rows hold ordinary transfers; hand tests follow.
`timescale 1ns/10ps
module tb_rev_nibble_byte_engine;
	import p1284_rev_pkg::*;
	typedef struct {
		mode_e mode;
		logic [7:0] data;
		logic more;
	} row_s;
	localparam int NROWS = 7;
	row_s rows [NROWS] = '{
		'{MODE_HOST_NIBBLE, 8'hA5, 1'b1},
		'{MODE_HOST_NIBBLE, 8'h3C, 1'b0},
		'{MODE_HOST_NIBBLE, 8'hFF, 1'b0},
		'{MODE_HOST_BYTE, 8'h96, 1'b1},
		'{MODE_HOST_BYTE, 8'h00, 1'b0},
		'{MODE_PERIPH_NIBBLE, 8'hC3, 1'b1},
		'{MODE_PERIPH_NIBBLE, 8'h5A, 1'b0}};
	logic [4:0] ofs [4] = '{OFS_MODE, OFS_CTRL, OFS_TIMING, OFS_STATUS};
	logic [31:0] rv [4] = '{32'h0, 32'(CTRL_RESET), 32'(TIMING_RESET),
		32'h0};
	logic clk;
	logic reset = 1'b1;
	logic [4:0] address = 5'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	pins_in_s pinsIn;
	pins_out_s pinsOut;
	logic lineActive = 1'b1;
	logic lineInit = 1'b1;
	logic timedOut;
	logic [31:0] rd;
	logic [7:0] rx;
	int nFail = 0;
	int testsRun = 0;

	rev_nibble_byte_engine i_rev_nibble_byte_engine (.clk(clk),
		.reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .pinsIn(pinsIn), .pinsOut(pinsOut));
	p1284_peer i_p1284_peer (.clk(clk), .lineActive(lineActive),
		.lineInit(lineInit), .pinsOut(pinsOut), .pinsIn(pinsIn),
		.timedOut(timedOut));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			nFail++;
		end
	endtask

	task automatic give_up(input string what);
		$display("mismatch %s expected done seen timeout", what);
		nFail++;
		close_out();
	endtask

	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= ~wr;
		do begin
			@(negedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50) give_up("waitrequest");
		@(posedge clk);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic poll(input int bitNo, input string what);
		int n = 0;
		do begin
			bus(1'b0, OFS_STATUS, 32'h0, rd);
			n++;
		end while (rd[bitNo] !== 1'b1 && n < 500);
		if (n >= 500) give_up(what);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		wr(OFS_CTRL, 32'h1F5);
		for (int i = 0; i < NROWS; i++) begin
			if (i == 0 || rows[i-1].mode != rows[i].mode || !rows[i-1].more) begin
				wr(OFS_MODE, 32'(rows[i].mode));
				if (rows[i].mode == MODE_PERIPH_NIBBLE) begin
					bus(1'b0, OFS_STATUS, 32'h0, rd);
					check("entry flags", 32'h3, rd & 32'h3);
				end
			end
			if (rows[i].mode == MODE_PERIPH_NIBBLE) begin
				wr(OFS_HOLD, 32'(rows[i].data));
				i_p1284_peer.take_byte(rx);
				poll(ST_IDLE, "idle after send");
				check("sent byte", 32'(rows[i].data), 32'(rx));
				check("restored lines", 32'h5, 32'(pinsOut.status));
			end else begin
				i_p1284_peer.send_byte(rows[i].data, rows[i].more,
					rows[i].mode == MODE_HOST_BYTE);
				poll(ST_REQUEST, "request");
				bus(1'b0, OFS_TRANSFER, 32'h0, rd);
				check("received byte", 32'(rows[i].data), rd);
				if (!rows[i].more) poll(ST_IDLE, "idle after last");
			end
			check("peer wait", 32'h0, 32'(timedOut));
			$display("test row %0d done", i);
		end
		// Cable events and an abort at the idle step
		lineActive <= 1'b0;
		repeat (3) @(posedge clk);
		lineActive <= 1'b1;
		repeat (3) @(posedge clk);
		bus(1'b0, OFS_STATUS, 32'h0, rd);
		check("abort flags", 32'hF, rd & 32'hF);
		wr(OFS_STATUS, 32'hC);
		lineInit <= 1'b0;
		repeat (3) @(posedge clk);
		bus(1'b0, OFS_STATUS, 32'h0, rd);
		check("init event", 32'hB, rd & 32'hF);
		wr(OFS_MODE, 32'(MODE_PERIPH_NEG));
		$display("test cable events done");
		// Host byte with a two-cycle delay and a pError pulse on the status lines
		wr(OFS_STATUS, 32'h8);
		wr(OFS_TIMING, 32'h2);
		wr(OFS_MODE, 32'(MODE_HOST_BYTE));
		bus(1'b0, OFS_STATUS, 32'h0, rd);
		check("byte entry idle", 32'h0, rd & 32'h2);
		i_p1284_peer.statusDrv[2] <= 1'b1;
		repeat (2) @(posedge clk);
		i_p1284_peer.statusDrv[2] <= 1'b0;
		i_p1284_peer.send_byte(8'h81, 1'b0, 1'b1);
		poll(ST_REQUEST, "request");
		bus(1'b0, OFS_TRANSFER, 32'h0, rd);
		check("short delay byte", 32'h81, rd);
		poll(ST_IDLE, "idle");
		check("no events", 32'h0, rd & 32'h8);
		$display("test short delay done");
		wr(5'h18, 32'h5A);
		bus(1'b0, 5'h18, 32'h0, rd);
		check("unmapped read", 32'h0, rd);
		$display("test unmapped done");
		reset <= 1'b1;
		repeat (8) @(posedge clk);
		check("pins in reset", 32'h7DF, 32'(pinsOut));
		reset <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, ofs[k], 32'h0, rd);
			check("reset value", rv[k], rd);
		end
		$display("test reset done");
		close_out();
	end
endmodule
